/* rtl/wspm_pkg.sv */
/*
  Shared constants and carrier types of the wait and stop power-mode
  controller: register offsets, field layouts, reset values, wake-source
  indices, bus answers and the power-state encoding.
  Assumes a 32-bit AXI4-Lite register bus and one system clock.
*/
package wspm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CLK_CTRL = 8'h00;
  localparam logic [7:0] OFS_WAIT_CMD = 8'h04;
  localparam logic [7:0] OFS_WAKE_CFG = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0C;

  localparam int CLK_CTRL_W = 11;
  localparam int WAKE_CFG_W = 14;
  localparam int WAIT_CMD_BIT = 0;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] cpu_div_sel;
    logic       cpu_onchip_select;
    logic       cpu_sub_select;
    logic       pll_enable;
    logic       osc_stop_detect_enable;
    logic       main_osc_high_drive;
    logic       cpu_pll_source_select;
    logic       cpu_div8_select;
    logic       wait_periph_clock_gate;
    logic       all_clocks_off;
  } wspm_clk_ctrl_t;

  typedef struct packed {
    logic       tmrb_low_speed;
    logic       tmrb_event;
    logic       tmra_low_speed;
    logic       tmra_event;
    logic       adc_single;
    logic       serial_ext_clk;
    logic [7:0] irq_enable;
  } wspm_wake_cfg_t;

  localparam logic [CLK_CTRL_W-1:0] CLK_CTRL_RST = 11'h014;
  localparam logic [WAKE_CFG_W-1:0] WAKE_CFG_RST = 14'h0000;

  // Bit 7 of the wake configuration word is the global interrupt flag.
  localparam int SRC_NMI    = 0;
  localparam int SRC_KEY    = 1;
  localparam int SRC_INT    = 2;
  localparam int SRC_SERIAL = 3;
  localparam int SRC_ADC    = 4;
  localparam int SRC_TMRA   = 5;
  localparam int SRC_TMRB   = 6;
  localparam int SRC_VDET   = 7;
  localparam int NUM_SRC    = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_WAIT = 2'b01,
    ST_STOP = 2'b10,
    ST_WAKE = 2'b11
  } wspm_state_t;

endpackage

/* rtl/wspm_ctrl.sv */
/*
  Wait and stop power-mode controller with an AXI4-Lite register slave.
  Assumes synchronous wake requests, a CPU that issues the wait command
  over the bus, and a clock generator that obeys the enable outputs.
*/
module wspm_ctrl #(
  parameter int ADDR_W = 8
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       ce,
  input  wire logic [ADDR_W-1:0]          awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [ADDR_W-1:0]          araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire logic [7:0]                 irq_req,
  output wspm_pkg::wspm_clk_ctrl_t        clk_cfg,
  output logic                            cpu_clk_en,
  output logic                            periph_clk_en,
  output logic                            low_speed_timer_clock_en,
  output logic                            osc_en,
  output logic                            pin_hold,
  output logic                            wake_irq
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 4 and 32.");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_strb(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] qualify(
    input logic [7:0]               req,
    input wspm_pkg::wspm_wake_cfg_t c,
    input logic                     in_stop,
    input logic                     gate
  );
    logic [7:0] ok;
    logic [7:0] en;
    logic       ext_only;
    ok = 8'h00;
    en = c.irq_enable & {8{c.irq_enable[wspm_pkg::SRC_VDET]}};
    ext_only = in_stop | gate;
    ok[wspm_pkg::SRC_NMI]    = 1'b1;
    ok[wspm_pkg::SRC_KEY]    = 1'b1;
    ok[wspm_pkg::SRC_INT]    = 1'b1;
    ok[wspm_pkg::SRC_SERIAL] = !ext_only || c.serial_ext_clk;
    ok[wspm_pkg::SRC_ADC]    = !ext_only && c.adc_single;
    ok[wspm_pkg::SRC_TMRA]   = !ext_only || c.tmra_event ||
                               (gate && !in_stop && c.tmra_low_speed);
    ok[wspm_pkg::SRC_TMRB]   = !ext_only || c.tmrb_event ||
                               (gate && !in_stop && c.tmrb_low_speed);
    ok[wspm_pkg::SRC_VDET]   = in_stop;
    // The global flag shares the top enable bit; NMI ignores both.
    en[wspm_pkg::SRC_NMI] = 1'b1;
    en[wspm_pkg::SRC_VDET] = c.irq_enable[wspm_pkg::SRC_VDET];
    return req & ok & en;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wspm_pkg::wspm_state_t    state, next_state;
  wspm_pkg::wspm_clk_ctrl_t next_clk_cfg;
  wspm_pkg::wspm_wake_cfg_t wake_cfg, next_wake_cfg;
  logic [7:0]               wake_cause, next_wake_cause;
  logic                     aw_held, next_aw_held;
  logic                     w_held, next_w_held;
  logic [ADDR_W-1:0]        aw_addr, next_aw_addr;
  logic [31:0]              w_data, next_w_data;
  logic [3:0]               w_strb, next_w_strb;
  logic                     next_awready, next_wready, next_arready;
  logic                     next_bvalid, next_rvalid, next_wake_irq;
  logic [1:0]               next_bresp, next_rresp;
  logic [31:0]              next_rdata;
  logic                     next_cpu_clk_en, next_periph_clk_en;
  logic                     next_lstc_en, next_osc_en, next_pin_hold;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0]              wr_val;
    logic [7:0]               qual, wa, ra;
    logic                     pll_mode, high_speed;
    wspm_pkg::wspm_clk_ctrl_t req_cfg;
    wr_val = 32'h0000_0000;
    req_cfg = clk_cfg;
    next_state = state;
    next_clk_cfg = clk_cfg;
    next_wake_cfg = wake_cfg;
    next_wake_cause = wake_cause;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_wake_irq = 1'b0;
    pll_mode = clk_cfg.cpu_pll_source_select;
    high_speed = !clk_cfg.cpu_sub_select && !clk_cfg.cpu_onchip_select &&
                 !clk_cfg.cpu_div8_select && (clk_cfg.cpu_div_sel == 2'b00);
    wa = 8'(aw_addr);
    ra = 8'(araddr);
    qual = qualify(irq_req, wake_cfg, state == wspm_pkg::ST_STOP,
                   clk_cfg.wait_periph_clock_gate);

    // Write address and data are taken in either order.
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end

    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wspm_pkg::RESP_OKAY;
      if (wa == wspm_pkg::OFS_CLK_CTRL) begin
        wr_val = merge_strb(32'(clk_cfg), w_data, w_strb);
        req_cfg = wspm_pkg::wspm_clk_ctrl_t'(wr_val[wspm_pkg::CLK_CTRL_W-1:0]);
        next_clk_cfg = req_cfg;
        next_clk_cfg.all_clocks_off = clk_cfg.all_clocks_off;
        if (pll_mode) begin
          // A PLL-driven CPU may only fall back to high-speed mode.
          next_clk_cfg = clk_cfg;
          next_clk_cfg.cpu_pll_source_select = req_cfg.cpu_pll_source_select;
          next_clk_cfg.pll_enable = req_cfg.pll_enable ||
                                    req_cfg.cpu_pll_source_select;
        end else if (req_cfg.cpu_pll_source_select &&
                     !(high_speed && clk_cfg.pll_enable)) begin
          next_clk_cfg.cpu_pll_source_select = 1'b0;
        end
        if (req_cfg.all_clocks_off && !pll_mode &&
            state == wspm_pkg::ST_RUN) begin
          next_state = wspm_pkg::ST_STOP;
          next_clk_cfg.all_clocks_off = 1'b1;
          next_clk_cfg.cpu_div8_select = 1'b1;
          next_clk_cfg.main_osc_high_drive = 1'b1;
        end
      end else if (wa == wspm_pkg::OFS_WAIT_CMD) begin
        wr_val = merge_strb(32'h0000_0000, w_data, w_strb);
        if (wr_val[wspm_pkg::WAIT_CMD_BIT] && !pll_mode &&
            state == wspm_pkg::ST_RUN) begin
          next_state = wspm_pkg::ST_WAIT;
        end
      end else if (wa == wspm_pkg::OFS_WAKE_CFG) begin
        wr_val = merge_strb(32'(wake_cfg), w_data, w_strb);
        next_wake_cfg =
          wspm_pkg::wspm_wake_cfg_t'(wr_val[wspm_pkg::WAKE_CFG_W-1:0]);
      end else if (wa == wspm_pkg::OFS_STATUS) begin
        next_bresp = wspm_pkg::RESP_OKAY;
      end else begin
        next_bresp = wspm_pkg::RESP_SLVERR;
      end
    end

    // Reads answer one cycle after the address is taken.
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = wspm_pkg::RESP_OKAY;
      if (ra == wspm_pkg::OFS_CLK_CTRL) begin
        next_rdata = 32'(clk_cfg);
      end else if (ra == wspm_pkg::OFS_WAIT_CMD) begin
        next_rdata = 32'h0000_0000;
      end else if (ra == wspm_pkg::OFS_WAKE_CFG) begin
        next_rdata = 32'(wake_cfg);
      end else if (ra == wspm_pkg::OFS_STATUS) begin
        next_rdata = {22'h00_0000, wake_cause, state};
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = wspm_pkg::RESP_SLVERR;
      end
    end

    // Power-state sequence.
    case (state)
      wspm_pkg::ST_WAIT, wspm_pkg::ST_STOP: begin
        if (|qual) begin
          // The clock setting is kept but for all_clocks_off, so a wait wake resumes
          // exactly; stop already holds the divide-by-8 it forced.
          next_state = wspm_pkg::ST_WAKE;
          next_wake_cause = qual;
          next_clk_cfg.all_clocks_off = 1'b0;
        end
      end
      wspm_pkg::ST_WAKE: begin
        next_state = wspm_pkg::ST_RUN;
        next_wake_irq = 1'b1;
      end
      default: begin
      end
    endcase

    next_awready = !next_aw_held;
    next_wready = !next_w_held;
    next_arready = !next_rvalid;

    next_cpu_clk_en = next_state == wspm_pkg::ST_RUN ||
                      next_state == wspm_pkg::ST_WAKE;
    next_osc_en = next_state != wspm_pkg::ST_STOP;
    next_periph_clk_en = next_cpu_clk_en ||
                         (next_state == wspm_pkg::ST_WAIT &&
                          !next_clk_cfg.wait_periph_clock_gate);
    next_lstc_en = next_state != wspm_pkg::ST_STOP;
    // Pins also hold through wait so both low-power states look alike.
    next_pin_hold = next_state == wspm_pkg::ST_STOP ||
                    next_state == wspm_pkg::ST_WAIT;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= wspm_pkg::ST_RUN;
      clk_cfg <= wspm_pkg::wspm_clk_ctrl_t'(wspm_pkg::CLK_CTRL_RST);
      wake_cfg <= wspm_pkg::wspm_wake_cfg_t'(wspm_pkg::WAKE_CFG_RST);
      wake_cause <= 8'h00;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      low_speed_timer_clock_en <= 1'b1;
      osc_en <= 1'b1;
      pin_hold <= 1'b0;
      wake_irq <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      clk_cfg <= next_clk_cfg;
      wake_cfg <= next_wake_cfg;
      wake_cause <= next_wake_cause;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      arready <= next_arready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      cpu_clk_en <= next_cpu_clk_en;
      periph_clk_en <= next_periph_clk_en;
      low_speed_timer_clock_en <= next_lstc_en;
      osc_en <= next_osc_en;
      pin_hold <= next_pin_hold;
      wake_irq <= next_wake_irq;
    end
  end

endmodule

/* dv/wspm_ctrl_props.sv */
/*
  Port checker of the wait and stop power-mode controller.
  Assumes it is bound onto wspm_ctrl and sees one clock domain.
*/
module wspm_ctrl_props (
  input wire logic                     aclk,
  input wire logic                     aresetn,
  input wire logic                     ce,
  input wire logic [7:0]               irq_req,
  input wire wspm_pkg::wspm_clk_ctrl_t clk_cfg,
  input wire logic                     cpu_clk_en,
  input wire logic                     periph_clk_en,
  input wire logic                     low_speed_timer_clock_en,
  input wire logic                     osc_en,
  input wire logic                     pin_hold,
  input wire logic                     wake_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic waiting;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Wait is the only state with the CPU clock off and oscillators on.
  assign waiting = !cpu_clk_en && osc_en;

  AST_STOP_CLKS: assert property (
    !osc_en |-> !cpu_clk_en && !periph_clk_en && !low_speed_timer_clock_en)
    else $error("clock left running in stop");
  AST_STOP_PINS: assert property (
    !osc_en |-> pin_hold)
    else $error("pins released in stop");
  AST_STOP_FORCE: assert property (
    $fell(osc_en) |-> clk_cfg.cpu_div8_select && clk_cfg.main_osc_high_drive
      && clk_cfg.all_clocks_off)
    else $error("stop entry did not force divider and drive");
  AST_WAIT_GATED: assert property (
    waiting && clk_cfg.wait_periph_clock_gate |->
      !periph_clk_en && low_speed_timer_clock_en)
    else $error("gated wait clocks wrong");
  AST_WAIT_UNGATED: assert property (
    waiting && !clk_cfg.wait_periph_clock_gate |-> periph_clk_en && pin_hold)
    else $error("ungated wait stopped peripheral clocks");
  AST_NMI_WAKE: assert property (
    ce && !cpu_clk_en && irq_req[0] |=> cpu_clk_en && osc_en && !pin_hold)
    else $error("non-maskable request did not wake");
  AST_WAKE_PULSE: assert property (
    $rose(cpu_clk_en) |-> !wake_irq ##1 wake_irq ##1 !wake_irq)
    else $error("routine pulse not after clock restart");
  AST_RESET_VALUES: assert property (disable iff (1'b0)
    !aresetn && ce |=> cpu_clk_en && osc_en && !pin_hold && !wake_irq
      && clk_cfg == wspm_pkg::CLK_CTRL_RST)
    else $error("reset did not restore run configuration");

  cover property ($fell(osc_en));
  cover property (waiting && clk_cfg.wait_periph_clock_gate);
  cover property ($rose(wake_irq));
endmodule

bind wspm_ctrl wspm_ctrl_props u_props (.aclk, .aresetn, .ce, .irq_req,
  .clk_cfg, .cpu_clk_en, .periph_clk_en, .low_speed_timer_clock_en,
  .osc_en, .pin_hold, .wake_irq);

/* dv/wspm_irq_src.sv */
/*
  Model of the interrupt sources beside the controller.
  Assumes the bench pulses fire for one cycle per request.
*/
module wspm_irq_src (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] fire,
  input  wire logic       wake_irq,
  output logic [7:0]      irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Requests stand as levels until the routine is entered, since a
  // request dropped early would be missed by the wake qualifier.
  always_ff @(posedge aclk) begin
    if (!aresetn || wake_irq) begin
      irq_req <= 8'h00;
    end else begin
      irq_req <= irq_req | fire;
    end
  end
endmodule

/* dv/tb_top.sv */
/*
  Self-checking bench of the power-mode controller.
  Assumes one 50 MHz clock and register access over AXI4-Lite.
*/
`define CHK(A, E) begin cmp_count++; if ((A) !== (E)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, (A), (E)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     aclk, aresetn, ce, awvalid, wvalid, bready;
  logic                     arvalid, rready, awready, wready, bvalid;
  logic                     arready, rvalid, wake_irq, pin_hold, osc_en;
  logic                     cpu_clk_en, periph_clk_en, lst_en;
  logic [7:0]               awaddr, araddr, fire, irq_req;
  logic [31:0]              wdata, rdata, rd;
  logic [3:0]               wstrb;
  logic [1:0]               bresp, rresp, rs;
  wspm_pkg::wspm_clk_ctrl_t clk_cfg;
  int                       n_mismatch, cmp_count, cycles;

  wspm_ctrl #(.ADDR_W(8)) u_wspm_ctrl (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq_req(irq_req),
    .clk_cfg(clk_cfg), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .low_speed_timer_clock_en(lst_en),
    .osc_en(osc_en), .pin_hold(pin_hold), .wake_irq(wake_irq));
  wspm_irq_src u_wspm_irq_src (.aclk(aclk), .aresetn(aresetn),
    .fire(fire), .wake_irq(wake_irq), .irq_req(irq_req));

  // --------
  // Bus and wake-wait tasks
  // --------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
  endtask

  task automatic wait_wake(output logic w);
    w = 1'b0;
    repeat (8) begin
      @(posedge aclk);
      if (wake_irq === 1'b1) w = 1'b1;
    end
  endtask

  // --------
  // Scenarios and final report
  // --------
  task automatic t_reset;
    axi_rd(8'h00, rd, rs);
    `CHK(rd, 32'h0000_0014)
    axi_rd(8'h10, rd, rs);
    `CHK({rs, rd}, {wspm_pkg::RESP_SLVERR, 32'h0})
    axi_wr(8'h10, 32'hFFFF_FFFF, rs);
    `CHK(rs, wspm_pkg::RESP_SLVERR)
    `CHK({cpu_clk_en, osc_en, pin_hold}, 3'b110)
  endtask

  task automatic t_wake(input logic [10:0] c, input logic [13:0] w,
                        input logic stop, input int src, input logic exp);
    logic       woke;
    logic [10:0] c_exp;
    c_exp = stop ? (c | 11'h014) : c;
    axi_wr(8'h08, {18'h0, w}, rs);
    axi_wr(8'h00, {21'h0, c[10:1], stop}, rs);
    if (!stop) axi_wr(8'h04, 32'h1, rs);
    `CHK({cpu_clk_en, osc_en, pin_hold}, {1'b0, ~stop, 1'b1})
    `CHK({periph_clk_en, lst_en}, {~stop & ~c[1], ~stop})
    if (stop) `CHK(clk_cfg, c_exp | 11'h001)
    fire <= 8'h01 << src;
    @(posedge aclk);
    fire <= 8'h00;
    wait_wake(woke);
    `CHK(woke, exp)
    if (!woke) begin
      fire <= 8'h01;
      @(posedge aclk);
      fire <= 8'h00;
      wait_wake(woke);
      `CHK(woke, 1'b1)
    end
    `CHK(clk_cfg, c_exp)
    axi_rd(8'h0C, rd, rs);
    `CHK(rd, {22'h0, (exp ? (8'h01 << src) : 8'h01), 2'b00})
  endtask

  task automatic t_pll;
    axi_wr(8'h00, 32'h0000_0040, rs);
    axi_wr(8'h00, 32'h0000_0048, rs);
    `CHK(clk_cfg, 11'h048)
    axi_wr(8'h04, 32'h1, rs);
    `CHK(cpu_clk_en, 1'b1)
    axi_wr(8'h00, 32'h0000_0049, rs);
    `CHK(osc_en, 1'b1)
    axi_wr(8'h00, 32'h0000_0000, rs);
    `CHK(clk_cfg, 11'h000)
    axi_wr(8'h00, 32'h0000_0004, rs);
    axi_wr(8'h00, 32'h0000_004C, rs);
    `CHK(clk_cfg.cpu_pll_source_select, 1'b0)
  endtask

  task automatic t_rst_wait;
    axi_wr(8'h08, 32'h0, rs);
    axi_wr(8'h00, 32'h0000_0602, rs);
    axi_wr(8'h04, 32'h1, rs);
    `CHK(cpu_clk_en, 1'b0)
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK({cpu_clk_en, pin_hold, clk_cfg}, {2'b10, 11'h014})
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, arvalid} = 4'b0;
    {bready, rready} = 2'b11;
    {awaddr, araddr, fire, wdata} = 56'h0;
    {n_mismatch, cmp_count} = 0;
    ce = 1'b1;
    wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_wake(11'h600, 14'h0082, 1'b0, 1, 1'b1);
    t_wake(11'h000, 14'h0002, 1'b0, 1, 1'b0);
    t_wake(11'h000, 14'h0088, 1'b0, 3, 1'b1);
    t_wake(11'h000, 14'h0290, 1'b0, 4, 1'b1);
    t_wake(11'h000, 14'h0090, 1'b0, 4, 1'b0);
    t_wake(11'h000, 14'h00C0, 1'b0, 6, 1'b1);
    t_wake(11'h002, 14'h0084, 1'b0, 2, 1'b1);
    t_wake(11'h002, 14'h0088, 1'b0, 3, 1'b0);
    t_wake(11'h002, 14'h0188, 1'b0, 3, 1'b1);
    t_wake(11'h002, 14'h0290, 1'b0, 4, 1'b0);
    t_wake(11'h002, 14'h00A0, 1'b0, 5, 1'b0);
    t_wake(11'h002, 14'h04A0, 1'b0, 5, 1'b1);
    t_wake(11'h002, 14'h20C0, 1'b0, 6, 1'b1);
    t_wake(11'h000, 14'h0082, 1'b1, 1, 1'b1);
    t_wake(11'h080, 14'h0080, 1'b1, 7, 1'b1);
    t_wake(11'h000, 14'h04A0, 1'b1, 5, 1'b1);
    t_wake(11'h000, 14'h08A0, 1'b1, 5, 1'b0);
    t_wake(11'h000, 14'h0088, 1'b1, 3, 1'b0);
    t_wake(11'h100, 14'h0090, 1'b1, 4, 1'b0);
    t_wake(11'h000, 14'h0000, 1'b1, 0, 1'b1);
    t_pll();
    t_rst_wait();
    report_and_stop();
  end
endmodule
